/* rsc_reset_source_controller.sv */
/*
  Reset source controller: merges power-on, supply monitor, pin,
  clock-loss, comparator, watchdog, flash error and software resets into
  one system reset, keeps the cause flags and the supply monitor control.
  Assumes rstn_in is the power-on reset, the analog levels and the pin are
  asynchronous, and watchdog and flash pulses come from clk_in logic.
*/
// How it works
// - In reset the core halts, registers default, pins known, interrupts off.
// - Reset never clears data memory; only registers reload.
// - Port latches load all ones and pull-ups stay on; ports are open drain only during reset.
// - Power-on and supply resets drive the reset pin low until exit.
// - On exit the program counter is zero and the internal oscillator runs.
// - After any reset the watchdog is on, clocked by system clock over twelve.
// - Power-on and supply resets set the power-on flag; every other cause clears it.
// - Of the resets, only power-on turns the supply monitor on; other resets keep its setting.
// - Supply below threshold, with the monitor on and selected, holds reset and drives the pin low.
// - Flash write or erase while the monitor is off forces a flash-error reset.
// - The monitor resets nothing unless also selected as a source.
// - Control bit 7 turns monitor on, bit 6 shows supply, bits 5-0 inert.
// - A low reset pin forces reset; its flag is set on exit.
// - Enabled clock-loss detector resets after 100 us stall and flags it.
// - Writing the clock-loss bit enables or disables the detector.
// - Clock-loss and comparator resets leave the reset pin undriven.
// - Enabled comparator starts a reset when its output goes low and flags it.
// - Writing one to the software bit forces reset; the bit then reads one.
// - Read-modify-write reads of dual bits return the enables, not flags.
`timescale 1ns/1ns
`default_nettype none
`include "rsc_defs.svh"

module rsc_reset_source_controller #(
  parameter int unsigned CLK_LOSS_CYCLES    = `RSC_CLK_LOSS_CYCLES,
  parameter int unsigned RESET_DELAY_CYCLES = `RSC_RESET_DELAY_CYCLES
) (
  // Clock and power-on reset
  input  wire logic                  clk_in,
  input  wire logic                  rstn_in,
  // Special function register access
  input  wire rsc_pkg::rsc_sfr_req_s sfr_req_in,
  output logic [7:0]                 sfr_rdata_out,
  // Reset pin, open drain
  input  wire logic                  rst_pin_in,
  output logic                       rst_pin_out,
  output logic                       rst_pin_oe_n_out,
  // Analog and on-chip reset sources
  input  wire logic                  supply_above_in,
  input  wire logic                  cmp_out_in,
  input  wire logic                  clock_stall_in,
  input  wire logic                  wdt_timeout_in,
  input  wire logic                  flash_wr_attempt_in,
  // Controls to the core
  output rsc_pkg::rsc_core_ctl_s     core_ctl_out
);
  import rsc_pkg::*;

  localparam int DW = $clog2(RESET_DELAY_CYCLES + 1);
  localparam int CW = $clog2(CLK_LOSS_CYCLES + 1);

  // ----------------------------------------------------------------------
  // Decode helper
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    hit = (a == reg_addr);
  endfunction : hit

  // ----------------------------------------------------------------------
  // Synchronisers: pin, supply, comparator, clock stall
  // ----------------------------------------------------------------------
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic       pin_s;
  logic       supply_s;
  logic       cmp_s;
  logic       stall_s;

  // Two stages; only the second stage is read by logic
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_q <= `RSC_SYNC_RESET;
      sync2_q <= `RSC_SYNC_RESET;
    end else begin
      sync1_q <= {rst_pin_in, supply_above_in, cmp_out_in, clock_stall_in};
      sync2_q <= sync1_q;
    end
  end

  assign pin_s    = sync2_q[3];
  assign supply_s = sync2_q[2];
  assign cmp_s    = sync2_q[1];
  assign stall_s  = sync2_q[0];

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  rsc_state_e    st_q, st_d;
  rsc_cause_s    cause_q, cause_d;
  rsc_cause_s    flags_q, flags_d;
  rsc_cause_s    req;
  logic          mon_on_q, mon_on_d;
  logic          mon_sel_q, mon_sel_d;
  logic          cmp_en_q, cmp_en_d;
  logic          closs_en_q, closs_en_d;
  logic [DW-1:0] dly_q, dly_d;
  logic [CW-1:0] closs_cnt_q, closs_cnt_d;
  logic [1:0]    blank_q, blank_d;
  logic          drive_q, drive_d;
  logic [7:0]    rdata_q, rdata_d;
  logic          run;
  logic          wr_src;
  logic          wr_ctl;
  logic          level_req;

  assign run    = (st_q == RSC_ST_RUN);
  assign wr_src = sfr_req_in.wr && hit(sfr_req_in.addr, `RSC_ADDR_RESET_SRC) && run;
  assign wr_ctl = sfr_req_in.wr && hit(sfr_req_in.addr, `RSC_ADDR_SUPPLY_CTL) && run;

  // Reset requests from every source
  always_comb begin
    req       = '0;
    req.por   = mon_on_q && mon_sel_q && !supply_s;
    req.pin   = !pin_s && (blank_q == 2'h0);
    req.cmp   = cmp_en_q && !cmp_s;
    req.closs = closs_en_q && (closs_cnt_q == CW'(CLK_LOSS_CYCLES));
    req.wdt   = wdt_timeout_in && run;
    req.ferr  = flash_wr_attempt_in && !mon_on_q && run;
    req.sw    = wr_src && sfr_req_in.wdata[`RSC_BIT_SW];
    level_req = req.por || req.pin || req.cmp || req.closs;
  end

  // Sequencer: enter on any request, hold while supply or pin levels stay, then delay
  always_comb begin
    st_d    = st_q;
    cause_d = cause_q;
    flags_d = flags_q;
    dly_d   = dly_q;
    case (st_q)
      RSC_ST_RUN: begin
        if (req != '0) begin
          st_d    = RSC_ST_HOLD;
          cause_d = req;
          dly_d   = '0;
        end
      end
      RSC_ST_HOLD: begin
        if (level_req) begin
          cause_d = cause_q | req;
          dly_d   = '0;
        end else if (dly_q == DW'(RESET_DELAY_CYCLES)) begin
          st_d    = RSC_ST_RUN;
          flags_d = cause_q;
        end else begin
          dly_d = dly_q + DW'(1);
        end
      end
      default: begin
        st_d = RSC_ST_HOLD;
      end
    endcase
  end

  // Enables, clock-loss count, pin blanking and read data
  always_comb begin
    mon_on_d    = mon_on_q;
    mon_sel_d   = mon_sel_q;
    cmp_en_d    = cmp_en_q;
    closs_en_d  = closs_en_q;
    closs_cnt_d = '0;
    blank_d     = (blank_q != 2'h0) ? blank_q - 2'h1 : 2'h0;
    rdata_d     = rdata_q;
    // Only a power-on or a software write moves the monitor setting
    if (wr_ctl) begin
      mon_on_d = sfr_req_in.wdata[`RSC_BIT_MON_ON];
    end
    if (wr_src) begin
      mon_sel_d  = sfr_req_in.wdata[`RSC_BIT_POR];
      cmp_en_d   = sfr_req_in.wdata[`RSC_BIT_CMP];
      closs_en_d = sfr_req_in.wdata[`RSC_BIT_CLOSS];
    end
    // Comparator and clock-loss enables return to defaults when reset is entered
    if (st_d == RSC_ST_HOLD) begin
      cmp_en_d   = 1'b0;
      closs_en_d = 1'b0;
    end
    // Saturating stall timer stands in for the one-shot
    if (closs_en_q && stall_s && run) begin
      closs_cnt_d = (closs_cnt_q == CW'(CLK_LOSS_CYCLES)) ? closs_cnt_q
                                                          : closs_cnt_q + CW'(1);
    end
    // Our own pin drive echoes back low through the synchroniser
    if (drive_q) begin
      blank_d = `RSC_PIN_BLANK;
    end
    if (sfr_req_in.rd) begin
      if (hit(sfr_req_in.addr, `RSC_ADDR_SUPPLY_CTL)) begin
        rdata_d = {mon_on_q, supply_s, 6'h00};
      end else if (hit(sfr_req_in.addr, `RSC_ADDR_RESET_SRC)) begin
        if (sfr_req_in.rmw) begin
          rdata_d = {1'b0, flags_q.ferr, cmp_en_q, 1'b0, flags_q.wdt,
                     closs_en_q, mon_sel_q, flags_q.pin};
        end else begin
          rdata_d = {1'b0, flags_q};
        end
      end else begin
        rdata_d = `RSC_RDATA_RESET;
      end
    end
  end

  // Pin is pulled low only for power-on and supply causes
  assign drive_d = (st_d == RSC_ST_HOLD) && cause_d.por;

  // Registers; power-on enables and selects the supply monitor
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q        <= RSC_ST_HOLD;
      cause_q     <= 7'h02;
      flags_q     <= '0;
      mon_on_q    <= 1'b1;
      mon_sel_q   <= 1'b1;
      cmp_en_q    <= 1'b0;
      closs_en_q  <= 1'b0;
      dly_q       <= '0;
      closs_cnt_q <= '0;
      blank_q     <= `RSC_PIN_BLANK;
      drive_q     <= 1'b1;
      rdata_q     <= `RSC_RDATA_RESET;
    end else begin
      st_q        <= st_d;
      cause_q     <= cause_d;
      flags_q     <= flags_d;
      mon_on_q    <= mon_on_d;
      mon_sel_q   <= mon_sel_d;
      cmp_en_q    <= cmp_en_d;
      closs_en_q  <= closs_en_d;
      dly_q       <= dly_d;
      closs_cnt_q <= closs_cnt_d;
      blank_q     <= blank_d;
      drive_q     <= drive_d;
      rdata_q     <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign sfr_rdata_out    = rdata_q;
  assign rst_pin_out      = 1'b0;
  assign rst_pin_oe_n_out = !drive_q;

  // Core held while in reset; memory gets no clear, only registers reload
  always_comb begin
    core_ctl_out              = '0;
    core_ctl_out.core_reset_n = run;
    core_ctl_out.pc           = `RSC_PC_RESET;
    core_ctl_out.osc_internal = 1'b1;
    core_ctl_out.wdt_en       = 1'b1;
    core_ctl_out.wdt_div      = `RSC_WDT_DIV;
    core_ctl_out.port_latch   = `RSC_PORT_LATCH_RESET;
    core_ctl_out.open_drain   = !run;
    core_ctl_out.pullup_en    = 1'b1;
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  a_pin_drive_por: assert property (
    (st_q == RSC_ST_HOLD && cause_q.por) |-> !rst_pin_oe_n_out)
    else $error("pin not driven during power or supply reset");

  a_pin_left_free: assert property (
    (st_q == RSC_ST_HOLD && !cause_q.por && (cause_q.cmp || cause_q.closs))
      |-> rst_pin_oe_n_out)
    else $error("pin driven for comparator or clock-loss reset");

  a_core_held_reset: assert property (
    (st_q == RSC_ST_HOLD) |-> !core_ctl_out.core_reset_n && core_ctl_out.open_drain
                              && core_ctl_out.port_latch == 8'hFF)
    else $error("core not held in defaults during reset");

  a_supply_low_hold: assert property (
    (run && mon_on_q && mon_sel_q && !supply_s) |=> (st_q == RSC_ST_HOLD) && !rst_pin_oe_n_out)
    else $error("supply low did not enter reset");

  a_unselected_quiet: assert property (
    (run && !mon_sel_q && !supply_s && !req.pin && !req.cmp && !req.closs
     && !req.wdt && !req.ferr && !req.sw) |=> run)
    else $error("unselected monitor caused reset");

  a_flash_err_reset: assert property (
    (run && flash_wr_attempt_in && !mon_on_q) |=> (st_q == RSC_ST_HOLD) && cause_q.ferr)
    else $error("flash write with monitor off missed");

  a_sw_reset_flag: assert property (
    (run && wr_src && sfr_req_in.wdata[`RSC_BIT_SW] && !level_req)
      |=> (st_q == RSC_ST_HOLD) && cause_q.sw)
    else $error("software reset not forced");

  a_monitor_kept: assert property (
    !wr_ctl |=> $stable(mon_on_q))
    else $error("monitor setting changed without a write");

  a_exit_flags: assert property (
    (st_q == RSC_ST_HOLD && st_d == RSC_ST_RUN) |=> run && flags_q == $past(cause_q)
      && (flags_q != '0))
    else $error("cause flags not loaded on exit");

  a_clk_loss_fire: assert property (
    (run && closs_en_q && closs_cnt_q == CW'(CLK_LOSS_CYCLES)) |=> cause_q.closs)
    else $error("clock-loss timeout missed");

  a_rmw_enable_read: assert property (
    (sfr_req_in.rd && sfr_req_in.rmw && hit(sfr_req_in.addr, `RSC_ADDR_RESET_SRC))
      |=> sfr_rdata_out[`RSC_BIT_CLOSS] == $past(closs_en_q)
          && sfr_rdata_out[`RSC_BIT_POR] == $past(mon_sel_q))
    else $error("read-modify-write read returned flags");

  c_por_exit: cover property ((st_q == RSC_ST_HOLD && cause_q.por) ##1 run);
  c_sw_reset: cover property (run && req.sw ##1 cause_q.sw);
  c_cmp_reset: cover property (run && req.cmp ##1 cause_q.cmp);
  c_pin_reset: cover property ((st_q == RSC_ST_HOLD && cause_q.pin) ##1 run);

endmodule : rsc_reset_source_controller

`default_nettype wire

/* rsc_defs.svh */
/*
  Constants of the reset source controller: register offsets, field
  positions, reset values and timing counts.
  Assumes a 100 MHz system clock and 8-bit special function registers.
*/
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RSC_ADDR_SUPPLY_CTL   8'hFF
`define RSC_ADDR_RESET_SRC    8'hEF

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RSC_BIT_MON_ON        7
`define RSC_BIT_SUPPLY_STAT   6
`define RSC_BIT_FERR          6
`define RSC_BIT_CMP           5
`define RSC_BIT_SW            4
`define RSC_BIT_WDT           3
`define RSC_BIT_CLOSS         2
`define RSC_BIT_POR           1
`define RSC_BIT_PIN           0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RSC_PORT_LATCH_RESET  8'hFF
`define RSC_PC_RESET          16'h0000
`define RSC_WDT_DIV           4'hC
`define RSC_RDATA_RESET       8'h00
`define RSC_SYNC_RESET        4'hE
`define RSC_PIN_BLANK         2'h3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RSC_CLK_PERIOD_NS     10
`define RSC_CLK_LOSS_NS       100000
`define RSC_RESET_DELAY_NS    40000
`define RSC_CLK_LOSS_CYCLES   ((`RSC_CLK_LOSS_NS) / (`RSC_CLK_PERIOD_NS))
`define RSC_RESET_DELAY_CYCLES \
  ((`RSC_RESET_DELAY_NS + `RSC_CLK_PERIOD_NS - 1) / (`RSC_CLK_PERIOD_NS))

`endif

/* rsc_pkg.sv */
/*
  Types of the reset source controller: state codes and carrier structs.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package rsc_pkg;

  // Controller states, one-hot
  typedef enum logic [1:0] {
    RSC_ST_HOLD = 2'b01,
    RSC_ST_RUN  = 2'b10
  } rsc_state_e;

  // One bit per reset cause
  typedef struct packed {
    logic ferr;
    logic cmp;
    logic sw;
    logic wdt;
    logic closs;
    logic por;
    logic pin;
  } rsc_cause_s;

  // Register access from the core
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic       rmw;
    logic [7:0] wdata;
  } rsc_sfr_req_s;

  // Reset controls handed to the core and its peripherals
  typedef struct packed {
    logic        core_reset_n;
    logic [15:0] pc;
    logic        osc_internal;
    logic        wdt_en;
    logic [3:0]  wdt_div;
    logic [7:0]  port_latch;
    logic        open_drain;
    logic        pullup_en;
  } rsc_core_ctl_s;

endpackage : rsc_pkg

`default_nettype wire

/* rsc_pin_model.sv */
/*
  Partner model: outside circuitry on the open-drain reset pin.
  Assumes a pull-up on the pin; the device and this model only pull low.
*/
`timescale 1ns/1ns
`default_nettype none

module rsc_pin_model (
  // Command from the bench
  input  wire logic hold_low_in,
  // Device side of the pin
  input  wire logic dev_level_in,
  input  wire logic dev_oe_n_in,
  // Resolved pin level
  output logic      pin_out
);
  // ----------------------------------------------------------------------
  // Wired-AND with pull-up
  // ----------------------------------------------------------------------
  // Released pin floats to the pull-up level, never the last driven value
  assign pin_out = ~(hold_low_in | (~dev_oe_n_in & ~dev_level_in));
endmodule : rsc_pin_model

`default_nettype wire

/* test_rsc_reset_source_controller.sv */
/*
  Self-checking bench of the reset source controller.
  Assumes rsc_pkg, rsc_defs.svh and the pin model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rsc_defs.svh"

module test_rsc_reset_source_controller;
  import rsc_pkg::*;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic          clk_in;
  logic          rstn_in;
  rsc_sfr_req_s  req;
  logic [7:0]    rdata;
  logic          pin;
  logic          pin_o;
  logic          oe_n;
  logic          supply;
  logic          cmp;
  logic          stall;
  logic          wdt;
  logic          flash;
  logic          hold_low;
  int            drive_seen = 0;
  int            drive_mark = 0;
  rsc_core_ctl_s ctl;
  int            miscompares;
  int            checks_done;
  int            cycles = 0;

  // Short counts keep the run brief
  rsc_reset_source_controller #(.CLK_LOSS_CYCLES(20), .RESET_DELAY_CYCLES(8)) u_dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .sfr_req_in(req), .sfr_rdata_out(rdata),
    .rst_pin_in(pin), .rst_pin_out(pin_o), .rst_pin_oe_n_out(oe_n),
    .supply_above_in(supply), .cmp_out_in(cmp), .clock_stall_in(stall),
    .wdt_timeout_in(wdt), .flash_wr_attempt_in(flash), .core_ctl_out(ctl));

  rsc_pin_model u_pin (.hold_low_in(hold_low), .dev_level_in(pin_o), .dev_oe_n_in(oe_n),
    .pin_out(pin));

  // ----------------------------------------------------------------------
  // Clock, pin-drive monitor, timeout
  // ----------------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Counts edges, and edges at which the device pulled the pin; scenarios
  // compare against a mark so that only this process writes the counts
  always @(posedge clk_in) begin
    if (oe_n === 1'b0) drive_seen <= drive_seen + 1;
    cycles <= cycles + 1;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("miscompares=%0d checks_done=%0d", miscompares, checks_done);
    if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    req <= '{addr: a, wr: 1'b1, rd: 1'b0, rmw: 1'b0, wdata: d};
    @(posedge clk_in);
    req.wr <= 1'b0;
  endtask : sfr_write

  // Read answer holds until the next read, so one spare edge is safe
  task automatic sfr_expect(input logic [7:0] a, input logic m, input logic [7:0] e);
    @(posedge clk_in);
    req <= '{addr: a, wr: 1'b0, rd: 1'b1, rmw: m, wdata: 8'h00};
    @(posedge clk_in);
    req.rd  <= 1'b0;
    req.rmw <= 1'b0;
    @(posedge clk_in);
    #1;
    check({8'h00, rdata}, {8'h00, e});
  endtask : sfr_expect

  task automatic wait_enter();
    int n;
    n = 0;
    while (ctl.core_reset_n !== 1'b0 && n < 200) begin
      @(posedge clk_in);
      #1;
      n++;
    end
  endtask : wait_enter

  task automatic wait_exit(output logic d);
    int n;
    n = 0;
    while (ctl.core_reset_n !== 1'b1 && n < 200) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    d = (drive_seen != drive_mark);
  endtask : wait_exit

  task automatic idle_check(input int n);
    repeat (n) @(posedge clk_in);
    #1;
    check({15'h0, ctl.core_reset_n}, 16'h1);
  endtask : idle_check

  task automatic pulse_and_flag(input logic is_wdt, input logic [7:0] flag);
    logic d;
    drive_mark = drive_seen;
    @(posedge clk_in);
    if (is_wdt) wdt <= 1'b1;
    else flash <= 1'b1;
    @(posedge clk_in);
    wdt   <= 1'b0;
    flash <= 1'b0;
    wait_enter();
    check({15'h0, ctl.core_reset_n}, 16'h0);
    wait_exit(d);
    check({15'h0, d}, 16'h0);
    sfr_expect(`RSC_ADDR_RESET_SRC, 1'b0, flag);
  endtask : pulse_and_flag

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic por_scn();
    logic d;
    wait_exit(d);
    check({15'h0, d}, 16'h1);
    check(ctl.pc, `RSC_PC_RESET);
    check({14'h0, ctl.osc_internal, ctl.pullup_en}, 16'h3);
    check({11'h0, ctl.wdt_en, ctl.wdt_div}, 16'h1C);
    sfr_expect(`RSC_ADDR_RESET_SRC, 1'b0, 8'h02);
    sfr_expect(`RSC_ADDR_SUPPLY_CTL, 1'b0, 8'hC0);
  endtask : por_scn

  task automatic sw_rmw_scn();
    logic d;
    drive_mark = drive_seen;
    sfr_write(`RSC_ADDR_RESET_SRC, 8'h12);
    wait_enter();
    wait_exit(d);
    check({15'h0, d}, 16'h0);
    sfr_expect(`RSC_ADDR_RESET_SRC, 1'b0, 8'h10);
    sfr_write(`RSC_ADDR_RESET_SRC, 8'h26);
    sfr_expect(`RSC_ADDR_RESET_SRC, 1'b1, 8'h26);
    sfr_expect(`RSC_ADDR_RESET_SRC, 1'b0, 8'h10);
  endtask : sw_rmw_scn

  task automatic monitor_scn();
    logic d;
    sfr_write(`RSC_ADDR_SUPPLY_CTL, 8'h3F);
    sfr_expect(`RSC_ADDR_SUPPLY_CTL, 1'b0, 8'h40);
    @(posedge clk_in) supply <= 1'b0;
    idle_check(20);
    @(posedge clk_in) supply <= 1'b1;
    sfr_write(`RSC_ADDR_RESET_SRC, 8'h12);
    wait_enter();
    wait_exit(d);
    sfr_expect(`RSC_ADDR_SUPPLY_CTL, 1'b0, 8'h40);
    pulse_and_flag(1'b0, 8'h40);
    sfr_write(`RSC_ADDR_SUPPLY_CTL, 8'h80);
    // Monitor settles for about 5 us before it is selected again
    repeat (500) @(posedge clk_in);
    // Deselected on purpose: an enabled but unselected monitor stays quiet
    sfr_write(`RSC_ADDR_RESET_SRC, 8'h00);
    supply <= 1'b0;
    idle_check(20);
    sfr_expect(`RSC_ADDR_SUPPLY_CTL, 1'b0, 8'h80);
    drive_mark = drive_seen;
    sfr_write(`RSC_ADDR_RESET_SRC, 8'h02);
    wait_enter();
    check({15'h0, ctl.core_reset_n}, 16'h0);
    repeat (10) @(posedge clk_in);
    supply <= 1'b1;
    wait_exit(d);
    check({15'h0, d}, 16'h1);
    sfr_expect(`RSC_ADDR_SUPPLY_CTL, 1'b0, 8'hC0);
  endtask : monitor_scn

  task automatic pin_scn();
    logic d;
    drive_mark = drive_seen;
    @(posedge clk_in) hold_low <= 1'b1;
    wait_enter();
    check({15'h0, ctl.core_reset_n}, 16'h0);
    repeat (10) @(posedge clk_in);
    hold_low <= 1'b0;
    wait_exit(d);
    check({15'h0, d}, 16'h0);
    sfr_expect(`RSC_ADDR_RESET_SRC, 1'b0, 8'h01);
  endtask : pin_scn

  task automatic closs_scn();
    logic d;
    sfr_write(`RSC_ADDR_RESET_SRC, 8'h02);
    stall <= 1'b1;
    idle_check(40);
    drive_mark = drive_seen;
    sfr_write(`RSC_ADDR_RESET_SRC, 8'h06);
    wait_enter();
    check({15'h0, ctl.core_reset_n}, 16'h0);
    @(posedge clk_in) stall <= 1'b0;
    wait_exit(d);
    check({15'h0, d}, 16'h0);
    sfr_expect(`RSC_ADDR_RESET_SRC, 1'b0, 8'h04);
  endtask : closs_scn

  task automatic cmp_scn();
    logic d;
    // Comparator output has stood high since start, so it is settled
    sfr_write(`RSC_ADDR_RESET_SRC, 8'h22);
    idle_check(10);
    drive_mark = drive_seen;
    @(posedge clk_in) cmp <= 1'b0;
    wait_enter();
    check({15'h0, ctl.core_reset_n}, 16'h0);
    @(posedge clk_in) cmp <= 1'b1;
    wait_exit(d);
    check({15'h0, d}, 16'h0);
    sfr_expect(`RSC_ADDR_RESET_SRC, 1'b0, 8'h20);
  endtask : cmp_scn

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    miscompares = 0;
    checks_done = 0;
    rstn_in  = 1'b0;
    req      = '0;
    supply   = 1'b1;
    cmp      = 1'b1;
    stall    = 1'b0;
    wdt      = 1'b0;
    flash    = 1'b0;
    hold_low = 1'b0;
    repeat (10) @(posedge clk_in);
    #1;
    check({15'h0, ctl.core_reset_n}, 16'h0);
    check({6'h0, ctl.port_latch, ctl.open_drain, ctl.pullup_en}, 16'h03FF);
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    // Scenarios race the cycle ceiling; whichever ends first closes the run
    fork
      begin
        por_scn();
        sw_rmw_scn();
        monitor_scn();
        pin_scn();
        closs_scn();
        cmp_scn();
        pulse_and_flag(1'b1, 8'h08);
      end
      begin
        wait (cycles >= 20000);
        miscompares++;
      end
    join_any
    wrap_up();
  end
endmodule : test_rsc_reset_source_controller

`default_nettype wire
